// ==== hw/das_adc_dev.sv ====
// Converter sequencer: setup decode, slots, modes and conversion timing
// How it works
// - Converts 12-bit result of the selected node
// - Setup word holds command, data, selector
// - Fixed node codes; four codes reserved
// - Node 11110 uses 2-bit die subselect
// - Up to eight slots, each a selector
// - Host loads as many slots as depth
// - Bad load keeps active slot, zeros others up to depth
// - Automatic mode converts on every frame; the design skips setup frames with command 010, 011 or 100
// - Command 010 enables key sequencing
// - Completion posts result, advances sequence pointer
// - Autoread shifts latest result each frame; the design does it only while a sequencing mode is on
// - Four conversion modes exist
// - The two sequencing modes exclude each other
// - Sequence runs 0 to N-1, wraps
// - Host sets depth and slots first
// - Re-enabling restarts at first slot
// - Host sets die subselect before sequencing
// - Several die nodes need key sequencing
// - Command codes 000 to 101 decoded
// - Depth code 000 means one slot
// - Conversion commands ignored while busy
// - Single immediate conversion stops automatic sequence
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module das_adc_dev #(
  parameter int CONV_CYCLES = das_pkg::CONV_CYCLES
) (
  input logic clk,
  input logic reset_n,
  input logic clk_en,
  das_link_if.dev link,
  output logic [4:0] mux_node,
  output logic [1:0] die_node,
  output logic conv_start,
  input logic [11:0] adc_code
);
  typedef enum logic [1:0] {
    DAS_IDLE = 2'b00,
    DAS_CONV = 2'b01,
    DAS_POST = 2'b11
  } das_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (CONV_CYCLES < 1 || CONV_CYCLES > 4095) begin : g_bad_cycles
    $error("CONV_CYCLES must lie in 1..4095");
  end

  das_state_t state_reg;
  logic [11:0] cnt_reg;
  logic busy_reg;
  logic conv_seq_reg;
  logic [4:0] conv_node_reg;
  logic [1:0] die_node_reg;
  logic conv_start_reg;
  logic [2:0] depth_reg;
  logic [4:0] slot_reg [8];
  logic [4:0] key_sel_reg;
  logic key_armed_reg;
  logic key_seq_reg;
  logic auto_seq_reg;
  logic [2:0] ptr_reg;
  logic [11:0] result_reg;
  logic [4:0] res_node_reg;
  logic rb_vld_reg;
  logic [16:0] rb_data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decode
  logic [2:0] cmd;
  logic [2:0] dat;
  logic [4:0] sel;
  logic setup_wr;
  logic key_hit;
  logic mode_wr;
  logic load_ok;
  logic start_now;
  logic start_key_seq;
  logic start_key_one;
  logic start_auto;
  logic start_any;
  logic start_seq;
  logic [4:0] start_node;

  // Field split of the setup word
  assign cmd = link.frm_data[das_pkg::CMD_MSB:das_pkg::CMD_LSB];
  assign dat = link.frm_data[das_pkg::DATA_MSB:das_pkg::DATA_LSB];
  assign sel = link.frm_data[das_pkg::SEL_MSB:das_pkg::SEL_LSB];
  assign setup_wr = link.frm_vld && (link.frm_kind == das_pkg::DAS_FRM_SETUP);
  assign key_hit = link.frm_vld && (link.frm_kind == das_pkg::DAS_FRM_KEY) &&
    (link.frm_data == das_pkg::KEY_CODE);
  // Mode commands do not themselves count as the trigger frame
  assign mode_wr = setup_wr && (cmd == das_pkg::DAS_CMD_KEY_SEQ ||
    cmd == das_pkg::DAS_CMD_AUTO_SEQ || cmd == das_pkg::DAS_CMD_SINGLE_NOW);
  // A slot beyond the depth or a reserved code is a bad load
  assign load_ok = (dat <= depth_reg) && !das_pkg::das_reserved(sel);

  // Conversion triggers, all dropped while busy
  assign start_now = setup_wr && (cmd == das_pkg::DAS_CMD_SINGLE_NOW) && !busy_reg;
  assign start_key_seq = key_hit && key_seq_reg && !busy_reg;
  assign start_key_one = key_hit && !key_seq_reg && key_armed_reg && !busy_reg;
  assign start_auto = link.frm_vld && auto_seq_reg && !mode_wr && !busy_reg;
  assign start_seq = start_key_seq || start_auto;
  assign start_any = start_now || start_key_one || start_seq;

  // Node chosen for the conversion being started
  always_comb begin
    if (start_now) begin
      start_node = sel;
    end else if (start_key_one) begin
      start_node = key_sel_reg;
    end else begin
      start_node = slot_reg[ptr_reg];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Depth and single key selection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      depth_reg <= das_pkg::DEPTH_RST;
      key_sel_reg <= das_pkg::SLOT_RST;
      key_armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (setup_wr && cmd == das_pkg::DAS_CMD_SET_DEPTH) begin
        depth_reg <= dat;
      end
      if (setup_wr && cmd == das_pkg::DAS_CMD_SINGLE_KEY && !busy_reg) begin
        key_sel_reg <= sel;
        key_armed_reg <= 1'b1;
      end else if (start_key_one) begin
        key_armed_reg <= 1'b0; // One key conversion per setup
      end
    end
  end

  // Sequencer slots, one register per entry
  for (genvar i = 0; i < 8; i++) begin : g_slot
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        slot_reg[i] <= das_pkg::SLOT_RST;
      end else if (clk_en && setup_wr && cmd == das_pkg::DAS_CMD_LOAD_SLOT) begin
        if (load_ok) begin
          if (dat == 3'(i)) begin
            slot_reg[i] <= sel;
          end
        end else if (3'(i) <= depth_reg && 3'(i) != ptr_reg) begin
          slot_reg[i] <= das_pkg::SLOT_RST;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_seq_reg <= 1'b0;
      auto_seq_reg <= 1'b0;
    end else if (clk_en && setup_wr) begin
      if (cmd == das_pkg::DAS_CMD_KEY_SEQ) begin
        key_seq_reg <= dat[0];
        if (dat[0]) begin
          auto_seq_reg <= 1'b0;
        end
      end else if (cmd == das_pkg::DAS_CMD_AUTO_SEQ) begin
        auto_seq_reg <= dat[0];
        if (dat[0]) begin
          key_seq_reg <= 1'b0;
        end
      end else if (start_now) begin
        auto_seq_reg <= 1'b0;
      end
    end
  end

  // Sequence pointer; a depth setup or a mode enable beats an advance in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_reg <= 3'h0;
    end else if (clk_en) begin
      if (setup_wr && (cmd == das_pkg::DAS_CMD_SET_DEPTH ||
          ((cmd == das_pkg::DAS_CMD_KEY_SEQ || cmd == das_pkg::DAS_CMD_AUTO_SEQ) && dat[0]))) begin
        ptr_reg <= 3'h0;
      end else if (state_reg == DAS_POST && conv_seq_reg && (key_seq_reg || auto_seq_reg)) begin
        ptr_reg <= (ptr_reg == depth_reg) ? 3'h0 : ptr_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= DAS_IDLE;
      cnt_reg <= 12'h000;
      busy_reg <= 1'b0;
      conv_seq_reg <= 1'b0;
      conv_node_reg <= das_pkg::SLOT_RST;
      die_node_reg <= das_pkg::DIE_GROUND;
      conv_start_reg <= 1'b0;
    end else if (clk_en) begin
      conv_start_reg <= 1'b0;
      unique case (state_reg)
        DAS_IDLE: begin
          if (start_any) begin
            state_reg <= DAS_CONV;
            cnt_reg <= 12'(CONV_CYCLES - 1);
            busy_reg <= 1'b1;
            conv_seq_reg <= start_seq;
            conv_node_reg <= start_node;
            conv_start_reg <= 1'b1;
            if (start_node == das_pkg::NODE_CONV_DIE) begin
              die_node_reg <= link.die_subsel;
            end
          end
        end
        DAS_CONV: begin
          if (cnt_reg == 12'h000) begin
            state_reg <= DAS_POST;
          end else begin
            cnt_reg <= cnt_reg - 12'h001;
          end
        end
        DAS_POST: begin
          state_reg <= DAS_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Result posting; reserved nodes read as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 12'h000;
      res_node_reg <= das_pkg::SLOT_RST;
    end else if (clk_en && state_reg == DAS_POST) begin
      result_reg <= das_pkg::das_reserved(conv_node_reg) ? 12'h000 : adc_code;
      res_node_reg <= conv_node_reg;
    end
  end

  // Readback of the last completed result on each frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_vld_reg <= 1'b0;
      rb_data_reg <= 17'h00000;
    end else if (clk_en) begin
      rb_vld_reg <= link.frm_vld && link.autoread_en && (key_seq_reg || auto_seq_reg);
      if (link.frm_vld) begin
        rb_data_reg <= {res_node_reg, result_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign mux_node = conv_node_reg;
  assign die_node = die_node_reg;
  assign conv_start = conv_start_reg;
  assign link.res = result_reg;
  assign link.res_node = res_node_reg;
  assign link.busy = busy_reg;
  assign link.key_seq_on = key_seq_reg;
  assign link.auto_seq_on = auto_seq_reg;
  assign link.seq_ptr = ptr_reg;
  assign link.rb_vld = rb_vld_reg;
  assign link.rb_data = rb_data_reg;
endmodule : das_adc_dev

// ==== pkg/das_pkg.sv ====
// Shared constants and types for the diagnostic converter sequencer
package das_pkg;
  // Setup word field positions
  localparam int CMD_MSB = 10;
  localparam int CMD_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam int RES_W = 12;

  // Sequencer commands
  typedef enum logic [2:0] {
    DAS_CMD_SET_DEPTH = 3'h0,
    DAS_CMD_LOAD_SLOT = 3'h1,
    DAS_CMD_KEY_SEQ = 3'h2,
    DAS_CMD_AUTO_SEQ = 3'h3,
    DAS_CMD_SINGLE_NOW = 3'h4,
    DAS_CMD_SINGLE_KEY = 3'h5
  } das_cmd_t;

  // Kinds of frame that travel over the link
  typedef enum logic [1:0] {
    DAS_FRM_NOP = 2'h0,
    DAS_FRM_SETUP = 2'h1,
    DAS_FRM_KEY = 2'h2
  } das_frame_t;

  // Node codes of the input node selector
  localparam logic [4:0] NODE_MAIN_TEMP = 5'h00;
  localparam logic [4:0] NODE_CONV_TEMP = 5'h01;
  localparam logic [4:0] NODE_RSVD_A = 5'h02;
  localparam logic [4:0] NODE_RSVD_B = 5'h05;
  localparam logic [4:0] NODE_RSVD_C = 5'h06;
  localparam logic [4:0] NODE_RSVD_D = 5'h13;
  localparam logic [4:0] NODE_CONV_DIE = 5'h1e;
  localparam logic [4:0] NODE_REFERENCE_OUTPUT = 5'h1f;
  // Die node subselect codes
  localparam logic [1:0] DIE_GROUND = 2'h0;
  localparam logic [1:0] DIE_INTERNAL_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] DIE_POSITIVE_MAIN_SUPPLY = 2'h2;
  localparam logic [1:0] DIE_NEGATIVE_MAIN_SUPPLY = 2'h3;

  localparam logic [15:0] KEY_CODE = 16'h1adc;
  localparam logic [2:0] DEPTH_RST = 3'h0;
  localparam logic [4:0] SLOT_RST = 5'h00;

  // Conversion time and its cycle count at the 4 ns clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Host register byte offsets
  localparam logic [4:0] OFS_SETUP = 5'h00;
  localparam logic [4:0] OFS_KEY = 5'h04;
  localparam logic [4:0] OFS_FRAME = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_READBACK = 5'h14;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int CTRL_AUTOREAD = 0;
  localparam int CTRL_DIE_LSB = 1;
  localparam int ST_NODE_LSB = 12;
  localparam int ST_BUSY = 17;
  localparam int ST_KEY_SEQ = 18;
  localparam int ST_AUTO_SEQ = 19;
  localparam int ST_PTR_LSB = 20;
  localparam int RB_NEW = 17;

  // Codes that select no node
  function automatic logic das_reserved(input logic [4:0] sel);
    return (sel == NODE_RSVD_A) || (sel == NODE_RSVD_B) || (sel == NODE_RSVD_C) ||
      (sel == NODE_RSVD_D);
  endfunction : das_reserved
endpackage : das_pkg

// ==== pkg/das_link_if.sv ====
// Link between the host controller and the converter sequencer
`timescale 1ns/1ps
interface das_link_if;
  logic frm_vld;
  das_pkg::das_frame_t frm_kind;
  logic [15:0] frm_data;
  logic [1:0] die_subsel;
  logic autoread_en;
  logic [11:0] res;
  logic [4:0] res_node;
  logic busy;
  logic key_seq_on;
  logic auto_seq_on;
  logic [2:0] seq_ptr;
  logic rb_vld;
  logic [16:0] rb_data;

  modport dev (
    input frm_vld, frm_kind, frm_data, die_subsel, autoread_en,
    output res, res_node, busy, key_seq_on, auto_seq_on, seq_ptr, rb_vld, rb_data
  );
  modport host (
    output frm_vld, frm_kind, frm_data, die_subsel, autoread_en,
    input res, res_node, busy, key_seq_on, auto_seq_on, seq_ptr, rb_vld, rb_data
  );
endinterface : das_link_if

// ==== hw/das_adc_host.sv ====
// Host controller: Avalon-MM registers turned into link frames
`timescale 1ns/1ps
module das_adc_host (
  input logic clk,
  input logic reset_n,
  input logic clk_en,
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  das_link_if.host link
);
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [2:0] ctrl_reg;
  logic frm_vld_reg;
  das_pkg::das_frame_t frm_kind_reg;
  logic [15:0] frm_data_reg;
  logic [16:0] rb_reg;
  logic rb_new_reg;
  logic req;
  logic acc;
  logic [31:0] rmux;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, the request completes on the next edge
  assign req = avs_read || avs_write;
  assign acc = req && !wait_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
    end else if (clk_en) begin
      wait_reg <= !(req && wait_reg);
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rmux = 32'h00000000;
    unique case (avs_address)
      das_pkg::OFS_CTRL: rmux[2:0] = ctrl_reg;
      das_pkg::OFS_STATUS: begin
        rmux[11:0] = link.res;
        rmux[das_pkg::ST_NODE_LSB +: 5] = link.res_node;
        rmux[das_pkg::ST_BUSY] = link.busy;
        rmux[das_pkg::ST_KEY_SEQ] = link.key_seq_on;
        rmux[das_pkg::ST_AUTO_SEQ] = link.auto_seq_on;
        rmux[das_pkg::ST_PTR_LSB +: 3] = link.seq_ptr;
      end
      das_pkg::OFS_READBACK: begin
        rmux[16:0] = rb_reg;
        rmux[das_pkg::RB_NEW] = rb_new_reg;
      end
      default: rmux = 32'h00000000;
    endcase
  end

  // Read data is captured as the wait cycle ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else if (clk_en && avs_read && wait_reg) begin
      rdata_reg <= rmux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control: autoread enable and die node subselect, held as levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= das_pkg::CTRL_RST;
    end else if (clk_en && acc && avs_write && avs_address == das_pkg::OFS_CTRL) begin
      ctrl_reg <= avs_writedata[2:0];
    end
  end

  // Each accepted write to a frame offset sends one frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frm_vld_reg <= 1'b0;
      frm_kind_reg <= das_pkg::DAS_FRM_NOP;
      frm_data_reg <= 16'h0000;
    end else if (clk_en) begin
      frm_vld_reg <= 1'b0;
      if (acc && avs_write) begin
        unique case (avs_address)
          das_pkg::OFS_SETUP: begin
            frm_vld_reg <= 1'b1;
            frm_kind_reg <= das_pkg::DAS_FRM_SETUP;
            frm_data_reg <= avs_writedata[15:0];
          end
          das_pkg::OFS_KEY: begin
            frm_vld_reg <= 1'b1;
            frm_kind_reg <= das_pkg::DAS_FRM_KEY;
            frm_data_reg <= avs_writedata[15:0];
          end
          das_pkg::OFS_FRAME: begin
            frm_vld_reg <= 1'b1;
            frm_kind_reg <= das_pkg::DAS_FRM_NOP;
            frm_data_reg <= 16'h0000;
          end
          default: frm_vld_reg <= 1'b0;
        endcase
      end
    end
  end

  // Latest readback; the new flag is set over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_reg <= 17'h00000;
      rb_new_reg <= 1'b0;
    end else if (clk_en) begin
      if (link.rb_vld) begin
        rb_reg <= link.rb_data;
        rb_new_reg <= 1'b1;
      end else if (acc && avs_read && avs_address == das_pkg::OFS_READBACK) begin
        rb_new_reg <= 1'b0;
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign link.frm_vld = frm_vld_reg;
  assign link.frm_kind = frm_kind_reg;
  assign link.frm_data = frm_data_reg;
  assign link.autoread_en = ctrl_reg[das_pkg::CTRL_AUTOREAD];
  assign link.die_subsel = ctrl_reg[das_pkg::CTRL_DIE_LSB +: 2];
endmodule : das_adc_host

// ==== verification/das_link_checker.sv ====
// Assertions on the link that joins the host controller and the converter sequencer
`timescale 1ns/1ps
module das_link_checker #(
  parameter int CONV_CYCLES = das_pkg::CONV_CYCLES
) (
  input logic clk,
  input logic reset_n,
  input logic clk_en,
  input logic frm_vld,
  input das_pkg::das_frame_t frm_kind,
  input logic [15:0] frm_data,
  input logic autoread_en,
  input logic [11:0] res,
  input logic [4:0] res_node,
  input logic busy,
  input logic key_seq_on,
  input logic auto_seq_on,
  input logic [2:0] seq_ptr,
  input logic rb_vld,
  input logic [16:0] rb_data
);
  default clocking cb @(posedge clk); endclocking
  // A frozen clock enable is no cycle of the design, so nothing is judged there
  default disable iff (!reset_n || !clk_en);
  ////////////////////////////////////////////////////////////////////////////////
  // Length of the running busy period; a counter keeps long counts out of repetitions
  logic [12:0] busy_cnt_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_reg <= 13'h0000;
    end else if (clk_en) begin
      busy_cnt_reg <= busy ? busy_cnt_reg + 13'h0001 : 13'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Setup frame carrying a given command
  sequence s_setup(logic [2:0] c);
    frm_vld && frm_kind == das_pkg::DAS_FRM_SETUP && frm_data[10:8] == c;
  endsequence
  // Frame that must be echoed on the readback path
  sequence s_echo;
    frm_vld && frm_kind != das_pkg::DAS_FRM_SETUP && autoread_en && (key_seq_on || auto_seq_on);
  endsequence
  a_now_starts: assert property (s_setup(3'h4) ##0 !busy |=> busy && !auto_seq_on)
    else $error("single conversion did not start or left automatic mode on");
  a_busy_ignores: assert property (s_setup(3'h4) ##0 busy |=> $stable(auto_seq_on))
    else $error("command taken while busy changed the mode");
  a_busy_len: assert property ($fell(busy) |-> busy_cnt_reg == CONV_CYCLES + 1)
    else $error("busy period has the wrong length");
  a_busy_bound: assert property (busy_cnt_reg <= CONV_CYCLES + 1)
    else $error("busy held too long");
  a_res_on_done: assert property (!$stable({res_node, res}) |-> $fell(busy))
    else $error("result changed outside conversion completion");
  a_seq_excl: assert property (!(key_seq_on && auto_seq_on))
    else $error("both sequencing modes on");
  a_key_enable: assert property (s_setup(3'h2) ##0 frm_data[5]
      |=> key_seq_on && !auto_seq_on && seq_ptr == 3'h0)
    else $error("key sequencing enable misbehaved");
  a_auto_enable: assert property (s_setup(3'h3) ##0 frm_data[5]
      |=> auto_seq_on && !key_seq_on && seq_ptr == 3'h0)
    else $error("automatic sequencing enable misbehaved");
  a_rb_frame: assert property (s_echo |=> rb_vld && rb_data == $past({res_node, res}))
    else $error("readback missing or wrong after a frame");
  a_rb_cause: assert property (rb_vld |-> $past(frm_vld))
    else $error("readback without a frame");
endmodule : das_link_checker

// ==== verification/diag_adc_sequencer_tb.sv ====
// Self-checking bench: host controller and converter sequencer joined by the link
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
module diag_adc_sequencer_tb;
  localparam int CONV = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] mux_node;
  logic [1:0] die_node;
  logic conv_start;
  logic [11:0] adc_code = 12'h000;
  logic [4:0] mux_seen;
  logic [1:0] die_seen;
  logic [4:0] ln = 5'h00;
  logic [11:0] lr = 12'h000;
  logic [31:0] q;
  logic [31:0] e;
  logic [4:0] nodes [5] = '{5'h1f, 5'h05, 5'h00, 5'h01, 5'h1e};
  logic [4:0] slots [3] = '{5'h0c, 5'h1f, 5'h14};
  int err_total = 0;
  int tests_run = 0;
  // Clock of 4 ns
  always #2 clk = ~clk;
  das_link_if lk();
  das_adc_host u_das_adc_host (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(lk));
  das_adc_dev #(.CONV_CYCLES(CONV)) u_das_adc_dev (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .link(lk), .mux_node(mux_node), .die_node(die_node), .conv_start(conv_start),
    .adc_code(adc_code));
  das_link_checker #(.CONV_CYCLES(CONV)) u_das_link_checker (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .frm_vld(lk.frm_vld), .frm_kind(lk.frm_kind), .frm_data(lk.frm_data),
    .autoread_en(lk.autoread_en), .res(lk.res), .res_node(lk.res_node), .busy(lk.busy),
    .key_seq_on(lk.key_seq_on), .auto_seq_on(lk.auto_seq_on), .seq_ptr(lk.seq_ptr),
    .rb_vld(lk.rb_vld), .rb_data(lk.rb_data));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run; also reached when a wait runs out
  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Setup word from command, data and selector
  function automatic logic [15:0] sw(logic [2:0] c, logic [2:0] t, logic [4:0] s);
    return {5'h00, c, t, s};
  endfunction : sw
  // One Avalon access, held until waitrequest is seen low; read data lands in q
  task automatic xfer(input logic [4:0] a, input logic w, input logic [15:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin err_total++; results(); end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
  // Wait for the converter to go idle
  task automatic wait_idle;
    int i;
    for (i = 0; i < 60 && lk.busy !== 1'b0; i++) @(posedge clk);
    if (i == 60) begin err_total++; results(); end
  endtask : wait_idle
  // Send one frame, catch the conversion start, then compare the status word
  task automatic conv(input logic [4:0] a, input logic [15:0] d, input logic [4:0] n,
      input logic [11:0] c, input logic [4:0] m);
    int i;
    adc_code <= c;
    xfer(a, 1'b1, d);
    for (i = 0; i < 20 && conv_start !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin err_total++; results(); end
    mux_seen = mux_node;
    die_seen = die_node;
    wait_idle();
    `CHK("node", n, mux_seen)
    lr = (n == 5'h05) ? 12'h000 : c;
    ln = n;
    xfer(das_pkg::OFS_STATUS, 1'b0, 16'h0000);
    `CHK("status", {9'h000, m, 1'b0, n, lr}, q)
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    xfer(das_pkg::OFS_STATUS, 1'b0, 16'h0000);
    `CHK("status reset", 32'h00000000, q)
    xfer(5'h18, 1'b1, 16'hffff);
    xfer(5'h18, 1'b0, 16'h0000);
    `CHK("unmapped", 32'h00000000, q)
    xfer(das_pkg::OFS_CTRL, 1'b1, 16'h0006);
    xfer(das_pkg::OFS_CTRL, 1'b0, 16'h0000);
    `CHK("ctrl", 32'h00000006, q)
    $display("Test registers done");
    // Single immediate conversions over a table of nodes, reserved one included
    for (int k = 0; k < 5; k++) begin
      conv(das_pkg::OFS_SETUP, sw(3'h4, 3'h0, nodes[k]), nodes[k], 12'h5a0 + 12'(k), 5'h00);
    end
    `CHK("die node", 2'h3, die_seen)
    // Second command lands while busy and must leave no trace
    adc_code <= 12'h321;
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h4, 3'h0, 5'h01));
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h4, 3'h0, 5'h00));
    repeat (2) @(posedge clk);
    wait_idle();
    xfer(das_pkg::OFS_STATUS, 1'b0, 16'h0000);
    `CHK("busy ignore", 32'h00001321, q)
    `CHK("busy node", 5'h01, mux_node)
    ln = 5'h01;
    lr = 12'h321;
    $display("Test single done");
    // Key sequencing over three slots with wrap and readback
    xfer(das_pkg::OFS_CTRL, 1'b1, 16'h0007);
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h0, 3'h2, 5'h00));
    for (int k = 0; k < 3; k++) xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h1, 3'(k), slots[k]));
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h2, 3'h1, 5'h00));
    for (int k = 0; k < 4; k++) begin
      e = {14'h0000, 1'b1, ln, lr};
      conv(das_pkg::OFS_KEY, 16'h1adc, slots[k % 3], 12'h100 + 12'(k),
        {3'((k + 1) % 3), 2'b01});
      xfer(das_pkg::OFS_READBACK, 1'b0, 16'h0000);
      `CHK("readback", e, q)
    end
    xfer(das_pkg::OFS_READBACK, 1'b0, 16'h0000);
    `CHK("readback clear", e & 32'h0001ffff, q)
    $display("Test key sequence done");
    // Automatic sequencing, restart on re-enable, stop by single conversion
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h3, 3'h1, 5'h00));
    conv(das_pkg::OFS_FRAME, 16'h0000, slots[0], 12'h200, 5'h06);
    conv(das_pkg::OFS_FRAME, 16'h0000, slots[1], 12'h201, 5'h0a);
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h3, 3'h0, 5'h00));
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h3, 3'h1, 5'h00));
    conv(das_pkg::OFS_FRAME, 16'h0000, slots[0], 12'h202, 5'h06);
    // A single conversion sent while busy must neither stop the sequence nor hold the pointer
    xfer(das_pkg::OFS_FRAME, 1'b1, 16'h0000);
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h4, 3'h0, 5'h01));
    wait_idle();
    conv(das_pkg::OFS_SETUP, sw(3'h4, 3'h0, 5'h01), 5'h01, 12'h203, 5'h08);
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h3, 3'h1, 5'h00));
    conv(das_pkg::OFS_FRAME, 16'h0000, slots[0], 12'h204, 5'h06);
    $display("Test auto sequence done");
    // Bad slot load keeps the active slot and clears the rest up to the depth
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h2, 3'h1, 5'h00));
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h1, 3'h5, 5'h1f));
    for (int k = 0; k < 3; k++) begin
      conv(das_pkg::OFS_KEY, 16'h1adc, (k == 0) ? slots[0] : 5'h00, 12'h300 + 12'(k),
        {3'((k + 1) % 3), 2'b01});
    end
    $display("Test bad load done");
    // Single key conversion on the die node
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h2, 3'h0, 5'h00));
    xfer(das_pkg::OFS_CTRL, 1'b1, 16'h0003);
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h5, 3'h0, 5'h1e));
    conv(das_pkg::OFS_KEY, 16'h1adc, 5'h1e, 12'h400, 5'h00);
    `CHK("die key", 2'h1, die_seen)
    $display("Test single key done");
    // Frozen clock enable holds the pending frame until it rises again
    adc_code <= 12'h500;
    xfer(das_pkg::OFS_SETUP, 1'b1, sw(3'h4, 3'h0, 5'h00));
    clk_en <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("frozen busy", 1'b0, lk.busy)
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("thawed busy", 1'b1, lk.busy)
    wait_idle();
    xfer(das_pkg::OFS_STATUS, 1'b0, 16'h0000);
    `CHK("thawed status", 32'h00000500, q)
    $display("Test clock enable done");
    results();
  end
endmodule : diag_adc_sequencer_tb
